// ==== hdl/lin_pkg.sv ====
// constants shared by the LIN break and wake-up serial block
// assumes a single 200 MHz core clock and AXI4-Lite register access
package lin_pkg;
  // register byte addresses
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] STAT_ADDR = 8'h04;
  localparam logic [7:0] TXDATA_ADDR = 8'h08;
  localparam logic [7:0] RXDATA_ADDR = 8'h0C;
  localparam logic [7:0] DIV_ADDR = 8'h10;
  localparam logic [7:0] IRQ_STAT_ADDR = 8'h14;
  localparam logic [7:0] IRQ_EN_ADDR = 8'h18;
  localparam logic [7:0] IRQ_CLR_ADDR = 8'h1C;
  // control register fields
  localparam int WAKE_BIT = 1;
  localparam int BREAK_BIT = 3;
  localparam int TRANSMIT_ENABLE_BIT_BIT = 5;
  localparam int SLEEP_BIT = 7;
  // status register fields
  localparam int SHIFT_EMPTY_BIT = 1;
  localparam int RX_IDLE_BIT = 6;
  localparam int RXFLAG_BIT = 0;
  localparam int TXBUF_EMPTY_BIT = 2;
  // interrupt status fields
  localparam int IRQ_RX_BIT = 0;
  localparam int IRQ_WAKE_BIT = 1;
  localparam int IRQ_BRK_BIT = 2;
  localparam int IRQ_W = 3;
  // frame shapes, divisor reset value and AXI response codes
  localparam logic [3:0] DATA_BITS = 4'h8;
  localparam logic [3:0] BREAK_ZEROS = 4'hC;
  localparam logic [15:0] DIV_RESET = 16'h00D8;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage

// ==== hdl/lin_tx.sv ====
// transmit shifter with holding register and break character support
// assumes bit_tick_in is a one-cycle pulse once per bit time
`timescale 1ns/10ps
`default_nettype none
module lin_tx (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic bit_tick_in,
  input wire logic transmit_enable_in,
  input wire logic send_break_in,
  input wire logic load_in,
  input wire logic [7:0] load_data_in,
  output logic tx_out,
  output logic buf_empty_out,
  output logic shift_empty_out,
  output logic break_done_out
);
  typedef enum {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_t;
  tx_state_t state_reg, state_next;
  logic [7:0] hold_reg, hold_next;
  logic hold_full_reg, hold_full_next;
  logic [7:0] tx_shift_register_reg, shift_next;
  logic [3:0] cnt_reg, cnt_next;
  logic brk_reg, brk_next;
  logic line_reg, line_next;
  logic done_reg, done_next;

  // next-state for holding register, shifter and line
  always_comb begin
    state_next = state_reg;
    hold_next = hold_reg;
    hold_full_next = hold_full_reg;
    shift_next = tx_shift_register_reg;
    cnt_next = cnt_reg;
    brk_next = brk_reg;
    line_next = line_reg;
    done_next = 1'b0;
    if (load_in) begin
      hold_next = load_data_in;
      hold_full_next = 1'b1;
    end
    case (state_reg)
      TX_IDLE: begin
        if (hold_full_reg && transmit_enable_in) begin
          // break ignores data
          // the request is still set in the cycle after its own stop bit;
          // masking it there lets a preloaded sync byte go out as data
          brk_next = send_break_in && !done_reg;
          shift_next = brk_next ? 8'h00 : hold_reg;
          hold_full_next = load_in;
          state_next = TX_START;
        end
      end
      TX_START: begin
        if (bit_tick_in) begin
          line_next = 1'b0;
          cnt_next = 4'h0;
          state_next = TX_DATA;
        end
      end
      TX_DATA: begin
        if (bit_tick_in) begin
          line_next = brk_reg ? 1'b0 : tx_shift_register_reg[cnt_reg[2:0]];
          cnt_next = cnt_reg + 4'h1;
          if (cnt_reg == (brk_reg ? lin_pkg::BREAK_ZEROS
                                  : lin_pkg::DATA_BITS))
            begin
            line_next = 1'b1;
            state_next = TX_STOP;
          end
        end
      end
      TX_STOP: begin
        if (bit_tick_in) begin
          done_next = brk_reg;
          brk_next = 1'b0;
          state_next = TX_IDLE;
        end
      end
      default: state_next = TX_IDLE;
    endcase
  end

  // state registers, line idles high
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= TX_IDLE;
      hold_reg <= 8'h00;
      hold_full_reg <= 1'b0;
      tx_shift_register_reg <= 8'h00;
      cnt_reg <= 4'h0;
      brk_reg <= 1'b0;
      line_reg <= 1'b1;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      hold_reg <= hold_next;
      hold_full_reg <= hold_full_next;
      tx_shift_register_reg <= shift_next;
      cnt_reg <= cnt_next;
      brk_reg <= brk_next;
      line_reg <= line_next;
      done_reg <= done_next;
    end
  end

  assign tx_out = line_reg;
  assign buf_empty_out = ~hold_full_reg;
  assign shift_empty_out = (state_reg == TX_IDLE);
  assign break_done_out = done_reg;
endmodule
`default_nettype wire

// ==== hdl/lin_serial.sv ====
// LIN serial port: wake-on-edge, break transmit, AXI4-Lite registers
// assumes synchronous AXI master on core_clk_in, rx line from a pin
//
// The register offsets and register access over AXI4-Lite were decided locally.
`timescale 1ns/10ps
`default_nettype none
module lin_serial (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic serial_rx_line_in,
  output logic tx_out,
  output logic irq_out,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP, RX_WAKE_LOW}
    rx_state_t;
  rx_state_t rx_state_reg, rx_state_next;
  logic [7:0] ctrl_reg, ctrl_next;
  logic [15:0] baud_divisor_reg, baud_divisor_next;
  logic [15:0] div_cnt_reg, div_cnt_next;
  logic [3:0] os_cnt_reg, os_cnt_next;
  logic [3:0] bit_cnt_reg, bit_cnt_next;
  logic [7:0] rx_shift_reg, rx_shift_next;
  logic [7:0] rx_data_register_reg, rx_data_next;
  logic rx_interrupt_flag_reg, rx_flag_next;
  logic [lin_pkg::IRQ_W-1:0] irq_stat_reg, irq_stat_next;
  logic [lin_pkg::IRQ_W-1:0] irq_en_reg, irq_en_next;
  logic sync1_reg, sync2_reg, rx_prev_reg;
  logic tick_reg, tick_next;
  logic irq_reg;
  logic aw_reg, aw_next, w_reg, w_next, bv_reg, bv_next;
  logic [7:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rv_reg, rv_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic tx_line, buf_empty, shift_empty, break_done;
  logic wr_fire, rd_fire, fall, rise, os_tick, tx_load, rx_begin;
  logic aw_rdy_reg, w_rdy_reg, ar_rdy_reg;

  // address is mapped when it hits one of the eight words
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= lin_pkg::IRQ_CLR_ADDR);
  endfunction

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      rx_prev_reg <= 1'b1;
    end else begin
      sync1_reg <= serial_rx_line_in;
      sync2_reg <= sync1_reg;
      rx_prev_reg <= sync2_reg;
    end
  end
  assign fall = rx_prev_reg & ~sync2_reg;
  assign rise = ~rx_prev_reg & sync2_reg;

  assign wr_fire = aw_reg && w_reg && !bv_reg;
  assign rd_fire = s_axi_arvalid && !rv_reg;
  assign tx_load = wr_fire && (awaddr_reg == lin_pkg::TXDATA_ADDR);
  assign os_tick = tick_reg && (os_cnt_reg == 4'hF);
  // low line in idle starts a normal frame unless wake watch or sleep
  assign rx_begin = (rx_state_reg == RX_IDLE) &&
    !ctrl_reg[lin_pkg::WAKE_BIT] && !sync2_reg &&
    !ctrl_reg[lin_pkg::SLEEP_BIT];

  // baud divider gives a 16x oversample pulse; frozen in sleep
  always_comb begin
    div_cnt_next = div_cnt_reg;
    tick_next = 1'b0;
    os_cnt_next = os_cnt_reg;
    if (!ctrl_reg[lin_pkg::SLEEP_BIT]) begin
      if (div_cnt_reg >= baud_divisor_reg) begin
        div_cnt_next = 16'h0000;
        tick_next = 1'b1;
      end else begin
        div_cnt_next = div_cnt_reg + 16'h0001;
      end
      if (tick_reg)
        os_cnt_next = os_cnt_reg + 4'h1;
      // restart the phase so start bit is sampled mid-bit
      if (rx_begin)
        os_cnt_next = 4'h8;
    end
  end

  // receiver, wake watcher and register updates
  always_comb begin
    rx_state_next = rx_state_reg;
    bit_cnt_next = bit_cnt_reg;
    rx_shift_next = rx_shift_reg;
    rx_data_next = rx_data_register_reg;
    rx_flag_next = rx_interrupt_flag_reg;
    ctrl_next = ctrl_reg;
    baud_divisor_next = baud_divisor_reg;
    irq_en_next = irq_en_reg;
    irq_stat_next = irq_stat_reg;
    if (rd_fire && s_axi_araddr == lin_pkg::RXDATA_ADDR)
      rx_flag_next = 1'b0;
    if (wr_fire && wstrb_reg[0]) begin
      if (awaddr_reg == lin_pkg::CTRL_ADDR)
        ctrl_next = wdata_reg[7:0];
      if (awaddr_reg == lin_pkg::IRQ_EN_ADDR)
        irq_en_next = wdata_reg[lin_pkg::IRQ_W-1:0];
      if (awaddr_reg == lin_pkg::IRQ_CLR_ADDR)
        irq_stat_next = irq_stat_reg & ~wdata_reg[lin_pkg::IRQ_W-1:0];
    end
    if (wr_fire && awaddr_reg == lin_pkg::DIV_ADDR) begin
      if (wstrb_reg[0])
        baud_divisor_next[7:0] = wdata_reg[7:0];
      if (wstrb_reg[1])
        baud_divisor_next[15:8] = wdata_reg[15:8];
    end
    if (break_done) begin
      ctrl_next[lin_pkg::BREAK_BIT] = 1'b0;
      irq_stat_next[lin_pkg::IRQ_BRK_BIT] = 1'b1;
    end
    case (rx_state_reg)
      RX_IDLE: begin
        if (ctrl_reg[lin_pkg::WAKE_BIT]) begin
          if (fall) begin
            rx_flag_next = 1'b1;
            irq_stat_next[lin_pkg::IRQ_WAKE_BIT] = 1'b1;
            rx_state_next = RX_WAKE_LOW;
          end
        end else if (rx_begin) begin
          rx_state_next = RX_START;
        end
      end
      RX_WAKE_LOW: begin
        if (rise) begin
          ctrl_next[lin_pkg::WAKE_BIT] = 1'b0;
          rx_state_next = RX_IDLE;
        end
      end
      RX_START: begin
        if (os_tick) begin
          bit_cnt_next = 4'h0;
          rx_state_next = sync2_reg ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        if (os_tick) begin
          rx_shift_next = {sync2_reg, rx_shift_reg[7:1]};
          bit_cnt_next = bit_cnt_reg + 4'h1;
          if (bit_cnt_reg == lin_pkg::DATA_BITS - 4'h1)
            rx_state_next = RX_STOP;
        end
      end
      RX_STOP: begin
        if (os_tick) begin
          rx_data_next = rx_shift_reg;
          rx_flag_next = 1'b1;
          irq_stat_next[lin_pkg::IRQ_RX_BIT] = 1'b1;
          rx_state_next = RX_IDLE;
        end
      end
      default: rx_state_next = RX_IDLE;
    endcase
  end

  // receive and control registers
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rx_state_reg <= RX_IDLE;
      bit_cnt_reg <= 4'h0;
      rx_shift_reg <= 8'h00;
      rx_data_register_reg <= 8'h00;
      rx_interrupt_flag_reg <= 1'b0;
      ctrl_reg <= 8'h00;
      baud_divisor_reg <= lin_pkg::DIV_RESET;
      irq_en_reg <= '0;
      irq_stat_reg <= '0;
      div_cnt_reg <= 16'h0000;
      os_cnt_reg <= 4'h0;
      tick_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      rx_state_reg <= rx_state_next;
      bit_cnt_reg <= bit_cnt_next;
      rx_shift_reg <= rx_shift_next;
      rx_data_register_reg <= rx_data_next;
      rx_interrupt_flag_reg <= rx_flag_next;
      ctrl_reg <= ctrl_next;
      baud_divisor_reg <= baud_divisor_next;
      irq_en_reg <= irq_en_next;
      irq_stat_reg <= irq_stat_next;
      div_cnt_reg <= div_cnt_next;
      os_cnt_reg <= os_cnt_next;
      tick_reg <= tick_next;
      irq_reg <= |(irq_stat_next & irq_en_next);
    end
  end

  // AXI4-Lite handshakes: one write and one read at a time
  always_comb begin
    aw_next = aw_reg;
    w_next = w_reg;
    bv_next = bv_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bresp_next = bresp_reg;
    rv_next = rv_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (s_axi_awvalid && !aw_reg && !bv_reg) begin
      aw_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_reg && !bv_reg) begin
      w_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_next = 1'b0;
      w_next = 1'b0;
      bv_next = 1'b1;
      bresp_next = mapped(awaddr_reg) ? lin_pkg::AXI_OKAY
                                      : lin_pkg::AXI_SLVERR;
    end
    if (bv_reg && s_axi_bready)
      bv_next = 1'b0;
    if (rv_reg && s_axi_rready)
      rv_next = 1'b0;
    if (rd_fire) begin
      rv_next = 1'b1;
      rresp_next = mapped(s_axi_araddr) ? lin_pkg::AXI_OKAY
                                        : lin_pkg::AXI_SLVERR;
      case (s_axi_araddr)
        lin_pkg::CTRL_ADDR: rdata_next = {24'h000000, ctrl_reg};
        lin_pkg::STAT_ADDR: rdata_next = {25'h0000000,
          rx_state_reg == RX_IDLE, 3'h0, buf_empty, shift_empty,
          rx_interrupt_flag_reg};
        lin_pkg::RXDATA_ADDR: rdata_next = {24'h000000,
          rx_data_register_reg};
        lin_pkg::DIV_ADDR: rdata_next = {16'h0000, baud_divisor_reg};
        lin_pkg::IRQ_STAT_ADDR: rdata_next = {29'h00000000, irq_stat_reg};
        lin_pkg::IRQ_EN_ADDR: rdata_next = {29'h00000000, irq_en_reg};
        default: rdata_next = 32'h00000000;
      endcase
    end
  end

  // bus registers
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      aw_reg <= 1'b0;
      w_reg <= 1'b0;
      bv_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      bresp_reg <= 2'h0;
      rv_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= 2'h0;
      aw_rdy_reg <= 1'b1;
      w_rdy_reg <= 1'b1;
      ar_rdy_reg <= 1'b1;
    end else begin
      aw_reg <= aw_next;
      w_reg <= w_next;
      bv_reg <= bv_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bresp_reg <= bresp_next;
      rv_reg <= rv_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      // ready kept in flops so every bus output leaves a register
      aw_rdy_reg <= !aw_next && !bv_next;
      w_rdy_reg <= !w_next && !bv_next;
      ar_rdy_reg <= !rv_next;
    end
  end

  // ready is high while the capture slot is free
  assign s_axi_awready = aw_rdy_reg;
  assign s_axi_wready = w_rdy_reg;
  assign s_axi_bvalid = bv_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = ar_rdy_reg;
  assign s_axi_rvalid = rv_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign irq_out = irq_reg;

  lin_tx u_tx (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .bit_tick_in(os_tick),
    .transmit_enable_in(ctrl_reg[lin_pkg::TRANSMIT_ENABLE_BIT_BIT]),
    .send_break_in(ctrl_reg[lin_pkg::BREAK_BIT]),
    .load_in(tx_load),
    .load_data_in(wdata_reg[7:0]),
    .tx_out(tx_line),
    .buf_empty_out(buf_empty),
    .shift_empty_out(shift_empty),
    .break_done_out(break_done)
  );
  assign tx_out = tx_line;

  // wake enable drops within a cycle of a rise
  property p_wake_clear;
    @(posedge core_clk_in) disable iff (rst_in)
      (rx_state_reg == RX_WAKE_LOW && rise) |=> !ctrl_reg[lin_pkg::WAKE_BIT];
  endproperty
  a_wake_clear: assert property (p_wake_clear)
    else $error("wake enable not cleared on rise");

  // wake fall sets flag next cycle
  property p_wake_flag;
    @(posedge core_clk_in) disable iff (rst_in)
      (rx_state_reg == RX_IDLE && ctrl_reg[lin_pkg::WAKE_BIT] && fall)
      |=> rx_interrupt_flag_reg && rx_state_reg == RX_WAKE_LOW;
  endproperty
  a_wake_flag: assert property (p_wake_flag)
    else $error("wake event did not set flag");

  // no normal reception while wake enabled in idle
  property p_wake_blocks;
    @(posedge core_clk_in) disable iff (rst_in)
      (rx_state_reg == RX_IDLE && ctrl_reg[lin_pkg::WAKE_BIT])
      |=> rx_state_reg != RX_START;
  endproperty
  a_wake_blocks: assert property (p_wake_blocks)
    else $error("receive started while wake enabled");

  // flag clears after a receive data read made in the wake-low state
  property p_read_clears;
    @(posedge core_clk_in) disable iff (rst_in)
      (rd_fire && s_axi_araddr == lin_pkg::RXDATA_ADDR &&
       rx_state_reg == RX_WAKE_LOW) |=> !rx_interrupt_flag_reg;
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("read did not clear flag");

  // break request dropped after break finishes
  property p_break_clear;
    @(posedge core_clk_in) disable iff (rst_in)
      break_done |-> shift_empty ##1 !ctrl_reg[lin_pkg::BREAK_BIT];
  endproperty
  a_break_clear: assert property (p_break_clear)
    else $error("break request not cleared");

  property p_sleep_stop;
    @(posedge core_clk_in) disable iff (rst_in)
      ctrl_reg[lin_pkg::SLEEP_BIT] |=> !tick_reg;
  endproperty
  a_sleep_stop: assert property (p_sleep_stop)
    else $error("bit clock ran in sleep");

  // edge seen only on synchronised samples
  property p_sync_edge;
    @(posedge core_clk_in) disable iff (rst_in)
      fall |-> $past(sync2_reg) && !sync2_reg;
  endproperty
  a_sync_edge: assert property (p_sync_edge)
    else $error("edge not from synchronised line");

  // shift empty low while a break is on the line
  property p_break_busy;
    @(posedge core_clk_in) disable iff (rst_in)
      (!tx_line && ctrl_reg[lin_pkg::BREAK_BIT]) |-> !shift_empty;
  endproperty
  a_break_busy: assert property (p_break_busy)
    else $error("shift empty during break");

  // the line stays low for the first eight cycles of a break
  property p_break_low;
    @(posedge core_clk_in) disable iff (rst_in)
      ($fell(tx_line) && ctrl_reg[lin_pkg::BREAK_BIT]) |->
        !tx_line [*8];
  endproperty
  a_break_low: assert property (p_break_low)
    else $error("break line went high early");

  c_wake: cover property (@(posedge core_clk_in)
    rx_state_reg == RX_WAKE_LOW ##1 rise);
  c_break: cover property (@(posedge core_clk_in) break_done);
  c_rx: cover property (@(posedge core_clk_in)
    rx_state_reg == RX_STOP && os_tick);
endmodule
`default_nettype wire

// ==== tb/lin_node.sv ====
// remote serial node model: drives the receive line, listens on tx
// assumes BIT core clocks per bit and an idle-high line
`timescale 1ns/10ps
`default_nettype none
module lin_node #(
  parameter int BIT = 16
) (
  input wire logic core_clk_in,
  input wire logic tx_in,
  output logic line_out
);
  // idle high, the pull-up level
  initial line_out = 1'b1;

  // hold the line for whole bit times, changing just after an edge
  task automatic hold(input logic lvl, input int nbits);
    @(posedge core_clk_in);
    line_out <= lvl;
    repeat (nbits * BIT - 1) @(posedge core_clk_in);
  endtask

  // first character zeros
  // start plus twelve zeros, so no early rising edge ends the wake
  task automatic wake_break();
    hold(1'b0, 13);
    hold(1'b1, 2);
  endtask

  // plain frame: start, eight bits lsb first, stop
  task automatic send_byte(input logic [7:0] b);
    hold(1'b0, 1);
    for (int i = 0; i < 8; i++) hold(b[i], 1);
    hold(1'b1, 2);
  endtask

  // sample a tx frame at mid-bit; returns in the middle of the stop bit
  task automatic catch_byte(output logic [7:0] b);
    while (tx_in !== 1'b0) @(posedge core_clk_in);
    repeat (BIT / 2) @(posedge core_clk_in);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge core_clk_in);
      b[i] = tx_in;
    end
    repeat (BIT) @(posedge core_clk_in);
  endtask

  // length in cycles of the next low run on tx
  task automatic low_run(output int n);
    n = 0;
    while (tx_in !== 1'b0) @(posedge core_clk_in);
    while (tx_in === 1'b0) begin
      n++;
      @(posedge core_clk_in);
    end
  endtask
endmodule
`default_nettype wire

// ==== tb/lin_serial_tb_top.sv ====
// self-checking bench for the LIN break and wake-up serial port
// assumes lin_node as the remote party and an AXI4-Lite master here
`timescale 1ns/10ps
`default_nettype none
module lin_serial_tb_top;
  localparam int BIT = 16; // divisor 0 gives 16 cycles a bit
  logic core_clk_in, rst_in, rx_line, tx_line, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  int n_fail, n_checks;
  logic [1:0] wr_resp; // response code of the last write

  lin_serial dut (.core_clk_in, .rst_in, .serial_rx_line_in(rx_line),
    .tx_out(tx_line), .irq_out(irq), .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  lin_node #(.BIT(BIT)) node (.core_clk_in(core_clk_in),
    .tx_in(tx_line), .line_out(rx_line));

  // 200 MHz core clock
  initial begin
    core_clk_in = 1'b0;
    forever #2.5 core_clk_in = ~core_clk_in;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic tally_and_finish();
    if (n_fail == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge core_clk_in);
      if (!aw && s_axi_awready === 1'b1) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready === 1'b1) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge core_clk_in);
    wr_resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge core_clk_in);
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk_in); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk_in); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge core_clk_in);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk(d & m, e);
  endtask

  // bounded poll until a status bit reads one
  task automatic poll(input logic [7:0] a, input int b);
    logic [31:0] d;
    logic [1:0] r;
    d = 32'h0;
    for (int k = 0; k < 500 && d[b] !== 1'b1; k++) axi_rd(a, d, r);
    chk({31'h0, d[b]}, 32'h1);
  endtask

  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    rdchk(lin_pkg::DIV_ADDR, 32'hFFFF, 32'h00D8);
    rdchk(lin_pkg::CTRL_ADDR, 32'hFF, 32'h0);
    rdchk(lin_pkg::STAT_ADDR, 32'h2, 32'h2);
    axi_rd(8'h20, d, r);
    chk({30'h0, r}, {30'h0, lin_pkg::AXI_SLVERR});
    chk(d, 32'h0);
    chk({31'h0, irq}, 32'h0);
    axi_wr(8'h22, 32'h0);
    chk({30'h0, wr_resp}, {30'h0, lin_pkg::AXI_SLVERR});
    axi_wr(lin_pkg::DIV_ADDR, 32'h0);
    chk({30'h0, wr_resp}, {30'h0, lin_pkg::AXI_OKAY});
  endtask

  // break then sync header, as a bus master would send it
  task automatic t_break();
    int n;
    logic [7:0] b;
    axi_wr(lin_pkg::CTRL_ADDR, 32'h28);
    fork
      node.low_run(n);
      begin
        axi_wr(lin_pkg::TXDATA_ADDR, 32'hFF);
        poll(lin_pkg::STAT_ADDR, lin_pkg::TXBUF_EMPTY_BIT);
        rdchk(lin_pkg::STAT_ADDR, 32'h2, 32'h0);
        axi_wr(lin_pkg::TXDATA_ADDR, 32'h55);
      end
    join
    chk((n > 12 * BIT && n <= 13 * BIT + 1) ? 32'h1 : 32'h0, 32'h1);
    node.catch_byte(b);
    chk({24'h0, b}, 32'h55);
    rdchk(lin_pkg::CTRL_ADDR, 32'h28, 32'h20);
    repeat (BIT) @(posedge core_clk_in);
    rdchk(lin_pkg::STAT_ADDR, 32'h2, 32'h2);
    rdchk(lin_pkg::IRQ_STAT_ADDR, 32'h4, 32'h4);
  endtask

  // wake on a falling edge, then one ordinary byte
  task automatic t_wake();
    logic [31:0] d;
    logic [1:0] r;
    rdchk(lin_pkg::STAT_ADDR, 32'h40, 32'h40);
    axi_wr(lin_pkg::IRQ_EN_ADDR, 32'h2);
    axi_wr(lin_pkg::CTRL_ADDR, 32'h2);
    fork
      node.wake_break();
    join_none
    repeat (12) @(posedge core_clk_in);
    chk({31'h0, irq}, 32'h1);
    rdchk(lin_pkg::STAT_ADDR, 32'h1, 32'h1);
    rdchk(lin_pkg::IRQ_STAT_ADDR, 32'h2, 32'h2);
    axi_rd(lin_pkg::RXDATA_ADDR, d, r);
    rdchk(lin_pkg::STAT_ADDR, 32'h1, 32'h0);
    rdchk(lin_pkg::CTRL_ADDR, 32'h2, 32'h2);
    wait fork;
    rdchk(lin_pkg::CTRL_ADDR, 32'h2, 32'h0);
    axi_wr(lin_pkg::IRQ_CLR_ADDR, 32'h2);
    axi_wr(lin_pkg::IRQ_EN_ADDR, 32'h0);
    chk({31'h0, irq}, 32'h0);
    node.send_byte(8'hA5);
    poll(lin_pkg::STAT_ADDR, lin_pkg::RXFLAG_BIT);
    chk({31'h0, irq}, 32'h0);
    axi_wr(lin_pkg::IRQ_EN_ADDR, 32'h1);
    repeat (2) @(posedge core_clk_in);
    chk({31'h0, irq}, 32'h1);
    rdchk(lin_pkg::RXDATA_ADDR, 32'hFF, 32'hA5);
    axi_wr(lin_pkg::IRQ_CLR_ADDR, 32'h1);
    repeat (2) @(posedge core_clk_in);
    chk({31'h0, irq}, 32'h0);
  endtask

  // a break sent at the full rate, received at 9/13 of it, ends right
  // at the start of the stop bit: divisor 12 gives 208 cycles a bit, and thirteen
  // low bits of 144 cycles last exactly nine of those
  task automatic t_slow_break();
    axi_wr(lin_pkg::DIV_ADDR, 32'hC);
    node.hold(1'b0, 13 * 9);
    node.hold(1'b1, 26);
    poll(lin_pkg::STAT_ADDR, lin_pkg::RXFLAG_BIT);
    rdchk(lin_pkg::RXDATA_ADDR, 32'hFF, 32'h00);
    axi_wr(lin_pkg::IRQ_CLR_ADDR, 32'h1);
    axi_wr(lin_pkg::DIV_ADDR, 32'h0);
  endtask

  // sleep stops the bit clock, so the line must not move
  task automatic t_sleep();
    logic [7:0] b;
    logic t0;
    axi_wr(lin_pkg::CTRL_ADDR, 32'hA0);
    axi_wr(lin_pkg::TXDATA_ADDR, 32'h0F);
    repeat (BIT) @(posedge core_clk_in);
    t0 = tx_line;
    repeat (4 * BIT) @(posedge core_clk_in);
    chk({31'h0, tx_line}, {31'h0, t0});
    axi_wr(lin_pkg::CTRL_ADDR, 32'h20);
    node.catch_byte(b);
    chk({24'h0, b}, 32'h0F);
  endtask

  // main sequence
  initial begin
    n_fail = 0;
    n_checks = 0;
    rst_in = 1'b1;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (10) @(posedge core_clk_in);
    rst_in <= 1'b0;
    @(posedge core_clk_in);
    t_reset();
    t_break();
    t_wake();
    t_slow_break();
    t_sleep();
    tally_and_finish();
  end

  // watchdog: the whole run needs a few thousand cycles
  initial begin
    repeat (20000) @(posedge core_clk_in);
    n_fail++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
